// *** logic/ctx_core_exec.sv ***
// Decode and sequencing of the subtract, swap, mask-test, trap and watchdog group.
// Assumes the core presents an opcode with a start pulse and operand values ready.
`timescale 1ns/1ps
module ctx_core_exec #(
    parameter logic [15:0] WDOG_RELOAD = ctx_pkg::WDOG_RELOAD_DEF
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        start,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  dstVal,
    input  wire logic [7:0]  srcVal,
    input  wire logic [15:0] vectorVal,
    output logic             busy,
    output logic             done,
    output logic [7:0]       resultVal,
    output logic             resultWrite,
    output logic [7:0]       flags,
    output logic [15:0]      pc,
    output logic [7:0]       sp,
    output logic             stackWrite,
    output logic [7:0]       stackAddr,
    output logic [15:0]      stackData,
    output logic             stackWide,
    output logic             wdogTimeout,
    output logic [2:0]       fetchCycles,
    output logic [2:0]       execCycles
);
    import ctx_pkg::*;

    // ****************************************************************
    // Decode
    // ****************************************************************
    ctx_state_e  state_q;
    logic [2:0]  count_q;
    logic [7:0]  op_q;
    logic [7:0]  aluRes;
    logic [7:0]  aluFlags;
    logic        aluWrite;
    logic [2:0]  fetchSel;
    logic [2:0]  execSel;
    logic [15:0] wdog_q;

    ctx_alu uAlu (
        .opcode    (op_q),
        .dstVal    (dstVal),
        .srcVal    (srcVal),
        .flagsIn   (flags),
        .resultVal (aluRes),
        .flagsOut  (aluFlags),
        .writeBack (aluWrite)
    );

    // Cycle budget per opcode; indirect forms are the odd opcodes 63, 65, 67, 73, 75, 77.
    always_comb begin
        fetchSel = FETCH_ONE;
        execSel  = EXEC_DIRECT;
        if (opcode == OP_SUBF_RR || opcode == OP_SUBF_LIT || opcode == OP_TCMF_RR
            || opcode == OP_TCMF_LIT || opcode == OP_TMF_RR || opcode == OP_TMF_LIT) begin
            fetchSel = FETCH_FAR;
            execSel  = EXEC_FAR;
        end else if ((opcode >= OP_TCOMP_LO && opcode <= OP_TCOMP_HI)
                     || (opcode >= OP_TAND_LO && opcode <= OP_TAND_HI)) begin
            fetchSel = (opcode[3:0] < 4'h4) ? FETCH_WORK : FETCH_REG;
            execSel  = (opcode[3:0] == 4'h3 || opcode[3:0] == 4'h5 || opcode[3:0] == 4'h7)
                       ? EXEC_INDIR : EXEC_DIRECT;
        end else if (opcode == OP_SWAP_R || opcode == OP_SWAP_PTR) begin
            fetchSel = FETCH_SHORT;
            execSel  = opcode[0] ? EXEC_SWAP_I : EXEC_SWAP_R;
        end else if (opcode == OP_TRAP) begin
            fetchSel = FETCH_SHORT;
            execSel  = EXEC_TRAP;
        end else if (opcode == OP_WDOG) begin
            fetchSel = FETCH_ONE;
            execSel  = EXEC_WDOG;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Counts fetch then execute cycles; trap steps occupy its execute phase.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q     <= CTX_IDLE;
            count_q     <= CYC_RESET;
            op_q        <= 8'h00;
            fetchCycles <= CYC_RESET;
            execCycles  <= CYC_RESET;
        end else begin
            unique case (state_q)
                CTX_IDLE: begin
                    if (start) begin
                        op_q        <= opcode;
                        fetchCycles <= fetchSel;
                        execCycles  <= execSel;
                        count_q     <= fetchSel - 3'h1;
                        state_q     <= CTX_FETCH;
                    end
                end
                CTX_FETCH: begin
                    if (count_q == CYC_RESET) begin
                        count_q <= execCycles - 3'h1;
                        state_q <= (op_q == OP_TRAP) ? CTX_TRAP_PC : CTX_EXEC;
                    end else begin
                        count_q <= count_q - 3'h1;
                    end
                end
                CTX_EXEC, CTX_TRAP_PC, CTX_TRAP_FL, CTX_TRAP_VEC: begin
                    count_q <= count_q - 3'h1;
                    if (state_q == CTX_TRAP_PC && count_q == 3'h4) state_q <= CTX_TRAP_FL;
                    if (state_q == CTX_TRAP_FL && count_q == 3'h2) state_q <= CTX_TRAP_VEC;
                    if (count_q == CYC_RESET) state_q <= CTX_IDLE;
                end
            endcase
        end
    end

    assign busy = (state_q != CTX_IDLE);
    assign done = busy && (state_q != CTX_FETCH) && (count_q == CYC_RESET);
    // Mask tests leave the destination alone.
    assign resultWrite = done && aluWrite;
    assign resultVal   = aluRes;

    // Flags update on the last execute cycle; trap and refresh keep them.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            flags <= FLAGS_RESET;
        end else if (done && state_q == CTX_EXEC) begin
            flags <= aluFlags;
        end
    end

    // ****************************************************************
    // Trap stack sequence
    // ****************************************************************
    // Push PC at SP-2, flags at SP-3, then vector into PC.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sp         <= SP_RESET;
            pc         <= PC_RESET;
            stackWrite <= 1'b0;
            stackAddr  <= 8'h00;
            stackData  <= 16'h0000;
            stackWide  <= 1'b0;
        end else begin
            stackWrite <= 1'b0;
            if (state_q == CTX_TRAP_PC && count_q == 3'h5) begin
                sp         <= sp - SP_DEC_PC;
                stackAddr  <= sp - SP_DEC_PC;
                stackData  <= pc;
                stackWide  <= 1'b1;
                stackWrite <= 1'b1;
            end else if (state_q == CTX_TRAP_FL && count_q == 3'h3) begin
                sp         <= sp - SP_DEC_FL;
                stackAddr  <= sp - SP_DEC_FL;
                stackData  <= {8'h00, flags};
                stackWide  <= 1'b0;
                stackWrite <= 1'b1;
            end else if (state_q == CTX_TRAP_VEC && count_q == CYC_RESET) begin
                pc <= vectorVal;
            end
        end
    end

    // ****************************************************************
    // Watchdog
    // ****************************************************************
    // Refresh reloads the count at the end of the refresh opcode.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wdog_q      <= WDOG_RELOAD_DEF;
            wdogTimeout <= 1'b0;
        end else if (done && op_q == OP_WDOG) begin
            wdog_q      <= WDOG_RELOAD;
            wdogTimeout <= 1'b0;
        end else if (wdog_q == 16'h0000) begin
            wdogTimeout <= 1'b1;
        end else begin
            wdog_q <= wdog_q - 16'h0001;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_sub_dflag: assert property (@(posedge clk_sys) disable iff (reset)
        (done && state_q == CTX_EXEC && (op_q == OP_SUBF_RR || op_q == OP_SUBF_LIT))
        |=> flags[FLAG_D]) else $error("Subtract did not set D.");
    // Zero and sign must follow the swapped byte written back one cycle earlier.
    a_swap_zero: assert property (@(posedge clk_sys) disable iff (reset)
        (done && (op_q == OP_SWAP_R || op_q == OP_SWAP_PTR))
        |=> (flags[FLAG_Z] == ($past(resultVal) == 8'h00))
            && (flags[FLAG_S] == $past(resultVal[7])))
        else $error("Swap zero or sign flag wrong.");
    a_tcomp_vclr: assert property (@(posedge clk_sys) disable iff (reset)
        (done && op_q >= OP_TCOMP_LO && op_q <= OP_TCMF_LIT) |=> !flags[FLAG_V])
        else $error("Complement test left V set.");
    a_tcmf_cycles: assert property (@(posedge clk_sys) disable iff (reset)
        (state_q == CTX_IDLE && start && opcode == OP_TCMF_RR) |=> busy [*7] ##1 !busy)
        else $error("Far complement test cycle count wrong.");
    a_tand_vclr: assert property (@(posedge clk_sys) disable iff (reset)
        (done && op_q >= OP_TAND_LO && op_q <= OP_TMF_LIT) |=> !flags[FLAG_V])
        else $error("Mask test left V set.");
    a_tmf_cycles: assert property (@(posedge clk_sys) disable iff (reset)
        (state_q == CTX_IDLE && start && opcode == OP_TMF_LIT) |=> busy [*7] ##1 !busy)
        else $error("Far mask test cycle count wrong.");
    a_trap_flags: assert property (@(posedge clk_sys) disable iff (reset)
        (state_q == CTX_IDLE && start && opcode == OP_TRAP)
        |=> busy [*8] ##1 (!busy && $stable(flags)))
        else $error("Trap timing or flags wrong.");
    a_wdog_cycles: assert property (@(posedge clk_sys) disable iff (reset)
        (state_q == CTX_IDLE && start && opcode == OP_WDOG) |=> busy [*3] ##1 !busy)
        else $error("Refresh cycle count wrong.");
    a_tand_indir: assert property (@(posedge clk_sys) disable iff (reset)
        (state_q == CTX_IDLE && start && opcode == 8'h73) |=> busy [*6] ##1 !busy)
        else $error("Indirect mask test cycle count wrong.");
    a_wdog_reload: assert property (@(posedge clk_sys) disable iff (reset)
        (done && op_q == OP_WDOG) |=> (wdog_q == WDOG_RELOAD && !wdogTimeout))
        else $error("Refresh did not reload the watchdog.");
    a_mask_nowb: assert property (@(posedge clk_sys) disable iff (reset)
        (busy && ((op_q >= OP_TCOMP_LO && op_q <= OP_TCMF_LIT)
                  || (op_q >= OP_TAND_LO && op_q <= OP_TMF_LIT))) |-> !resultWrite)
        else $error("Mask test wrote back.");
    // The ALU itself must never ask for a write while a mask test is in flight.
    a_mask_nowrite: assert property (@(posedge clk_sys) disable iff (reset)
        (busy && ((op_q >= OP_TCOMP_LO && op_q <= OP_TCMF_LIT)
                  || (op_q >= OP_TAND_LO && op_q <= OP_TMF_LIT))) |-> !aluWrite)
        else $error("Mask test ALU asked for write back.");
    c_trap: cover property (@(posedge clk_sys) state_q == CTX_TRAP_VEC && count_q == 3'h0);
    c_sub: cover property (@(posedge clk_sys) done && op_q == OP_SUBF_LIT);
    c_poke: cover property (@(posedge clk_sys) busy && start);
    c_wdog: cover property (@(posedge clk_sys) done && op_q == OP_WDOG);

endmodule : ctx_core_exec

// *** logic/ctx_pkg.sv ***
// Constants, opcodes and cycle counts for the instruction decode and execute block.
// Assumes a core that fetches opcode and operand bytes and owns the register file.
package ctx_pkg;
    localparam logic [7:0] OP_SUBF_RR  = 8'h28;
    localparam logic [7:0] OP_SUBF_LIT = 8'h29;
    localparam logic [7:0] OP_SWAP_R   = 8'hF0;
    localparam logic [7:0] OP_SWAP_PTR = 8'hF1;
    localparam logic [7:0] OP_TCOMP_LO = 8'h62;
    localparam logic [7:0] OP_TCOMP_HI = 8'h67;
    localparam logic [7:0] OP_TCMF_RR  = 8'h68;
    localparam logic [7:0] OP_TCMF_LIT = 8'h69;
    localparam logic [7:0] OP_TAND_LO  = 8'h72;
    localparam logic [7:0] OP_TAND_HI  = 8'h77;
    localparam logic [7:0] OP_TMF_RR   = 8'h78;
    localparam logic [7:0] OP_TMF_LIT  = 8'h79;
    localparam logic [7:0] OP_TRAP     = 8'hF2;
    localparam logic [7:0] OP_WDOG     = 8'h5F;
    // Flag bit positions within the flags byte.
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;
    // Cycle counts, stack decrements and reset values.
    localparam logic [2:0] FETCH_FAR   = 3'h4;
    localparam logic [2:0] FETCH_WORK  = 3'h2;
    localparam logic [2:0] FETCH_REG   = 3'h3;
    localparam logic [2:0] FETCH_SHORT = 3'h2;
    localparam logic [2:0] FETCH_ONE   = 3'h1;
    localparam logic [2:0] EXEC_FAR    = 3'h3;
    localparam logic [2:0] EXEC_DIRECT = 3'h3;
    localparam logic [2:0] EXEC_INDIR  = 3'h4;
    localparam logic [2:0] EXEC_SWAP_R = 3'h2;
    localparam logic [2:0] EXEC_SWAP_I = 3'h3;
    localparam logic [2:0] EXEC_TRAP   = 3'h6;
    localparam logic [2:0] EXEC_WDOG   = 3'h2;
    localparam logic [2:0] CYC_RESET   = 3'h0;
    localparam logic [7:0] SP_DEC_PC   = 8'h02;
    localparam logic [7:0] SP_DEC_FL   = 8'h01;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET   = 16'h0000;
    localparam logic [7:0] SP_RESET    = 8'h00;
    localparam logic [15:0] WDOG_RELOAD_DEF = 16'hFFFF;
    typedef enum logic [2:0] {CTX_IDLE, CTX_FETCH, CTX_EXEC, CTX_TRAP_PC, CTX_TRAP_FL,
                              CTX_TRAP_VEC} ctx_state_e;
endpackage : ctx_pkg

// *** logic/ctx_alu.sv ***
// Combinational ALU for the subtract, swap and mask-test group.
// Assumes operands are already fetched by the core's operand path.
`timescale 1ns/1ps
module ctx_alu (
    input  wire logic [7:0] opcode,
    input  wire logic [7:0] dstVal,
    input  wire logic [7:0] srcVal,
    input  wire logic [7:0] flagsIn,
    output logic      [7:0] resultVal,
    output logic      [7:0] flagsOut,
    output logic            writeBack
);
    import ctx_pkg::*;

    logic [8:0] diff;
    logic [4:0] halfDiff;
    logic [7:0] masked;

    // Result and flag computation per opcode class.
    always_comb begin
        diff      = {1'b0, dstVal} - {1'b0, srcVal};
        halfDiff  = {1'b0, dstVal[3:0]} - {1'b0, srcVal[3:0]};
        masked    = 8'h00;
        resultVal = dstVal;
        flagsOut  = flagsIn;
        writeBack = 1'b0;
        if (opcode == OP_SUBF_RR || opcode == OP_SUBF_LIT) begin
            resultVal        = diff[7:0];
            writeBack        = 1'b1;
            flagsOut[FLAG_C] = diff[8];
            flagsOut[FLAG_Z] = (diff[7:0] == 8'h00);
            flagsOut[FLAG_S] = diff[7];
            flagsOut[FLAG_V] = (dstVal[7] != srcVal[7]) && (diff[7] != dstVal[7]);
            flagsOut[FLAG_D] = 1'b1;
            flagsOut[FLAG_H] = halfDiff[4];
        end else if (opcode == OP_SWAP_R || opcode == OP_SWAP_PTR) begin
            // Swap halves; C and V are undefined, so they are simply kept.
            resultVal        = {dstVal[3:0], dstVal[7:4]};
            writeBack        = 1'b1;
            flagsOut[FLAG_Z] = (dstVal == 8'h00);
            flagsOut[FLAG_S] = dstVal[3];
        end else if ((opcode >= OP_TCOMP_LO && opcode <= OP_TCMF_LIT)
                     || (opcode >= OP_TAND_LO && opcode <= OP_TMF_LIT)) begin
            masked = (opcode[4] ? dstVal : ~dstVal) & srcVal;
            flagsOut[FLAG_Z] = (masked == 8'h00);
            flagsOut[FLAG_S] = masked[7];
            flagsOut[FLAG_V] = 1'b0;
        end
    end

endmodule : ctx_alu

// *** bench/cpu_test_swap_trap_exec_tb.sv ***
// Self-checking bench for the subtract, swap, mask-test, trap and watchdog decode block.
// Assumes the design's own assertions sit in its files; the bench only drives and compares.
`timescale 1ns/1ps
module cpu_test_swap_trap_exec_tb;
    import ctx_pkg::*;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic        clk_sys   = 1'b0;
    logic        reset     = 1'b1;
    logic        start     = 1'b0;
    logic [7:0]  opcode    = 8'h00;
    logic [7:0]  dstVal    = 8'h00;
    logic [7:0]  srcVal    = 8'h00;
    logic [15:0] vectorVal = 16'h0000;
    logic        busy, done, resultWrite, stackWrite, stackWide, wdogTimeout;
    logic [7:0]  resultVal, flags, sp, stackAddr;
    logic [15:0] pc, stackData;
    logic [2:0]  fetchCycles, execCycles;
    logic [7:0]  expFlags, gotRes;
    logic        gotWr;
    logic [7:0]  wrAddr[$];
    logic [15:0] wrData[$];
    logic        wrWide[$];
    int          num_errors = 0;
    int          n_compared = 0;
    int          nCyc;
    int          feTab[6]  = '{2, 2, 3, 3, 3, 3};
    int          exTab[6]  = '{3, 4, 3, 4, 3, 4};

    // A short reload keeps the watchdog scenario well inside the run length.
    ctx_core_exec #(.WDOG_RELOAD(16'h0020)) dut (
        .clk_sys(clk_sys), .reset(reset), .start(start), .opcode(opcode), .dstVal(dstVal),
        .srcVal(srcVal), .vectorVal(vectorVal), .busy(busy), .done(done),
        .resultVal(resultVal), .resultWrite(resultWrite), .flags(flags), .pc(pc), .sp(sp),
        .stackWrite(stackWrite), .stackAddr(stackAddr), .stackData(stackData),
        .stackWide(stackWide), .wdogTimeout(wdogTimeout), .fetchCycles(fetchCycles),
        .execCycles(execCycles));

    // The clock toggles every 20 ns, half of its 40 ns period.
    always #20 clk_sys = ~clk_sys;

    // ************************************************************
    // Shared tasks and reference functions
    // ************************************************************
    // Every comparison goes through here so that counts stay honest.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // Single exit point for the run.
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d.", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // Borrow-style flags for the far subtract; the adjust flag is always forced high.
    function automatic logic [7:0] sub_flags(input logic [7:0] d, s, f);
        logic [8:0] r;
        logic [7:0] o;
        r = {1'b0, d} - {1'b0, s};
        o = f;
        o[FLAG_C] = r[8];
        o[FLAG_Z] = (r[7:0] == 8'h00);
        o[FLAG_S] = r[7];
        o[FLAG_V] = (d[7] != s[7]) && (r[7] != d[7]);
        o[FLAG_D] = 1'b1;
        o[FLAG_H] = (d[3:0] < s[3:0]);
        return o;
    endfunction : sub_flags

    // Zero and sign from a value; overflow cleared only where the operation asks.
    function automatic logic [7:0] zs_flags(input logic [7:0] v, f, input logic clrV);
        logic [7:0] o;
        o = f;
        o[FLAG_Z] = (v == 8'h00);
        o[FLAG_S] = v[7];
        if (clrV) begin
            o[FLAG_V] = 1'b0;
        end
        return o;
    endfunction : zs_flags

    // Issues one operation, optionally pokes start while busy, and logs stack writes.
    task automatic run_op(input logic [7:0] op, d, s, input logic poke, output int n);
        wrAddr.delete();
        wrData.delete();
        wrWide.delete();
        @(negedge clk_sys);
        opcode = op;
        dstVal = d;
        srcVal = s;
        start  = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        n = 1;
        forever begin
            if (stackWrite === 1'b1) begin
                wrAddr.push_back(stackAddr);
                wrData.push_back(stackData);
                wrWide.push_back(stackWide);
            end
            if (done === 1'b1 || n >= 20) break;
            @(negedge clk_sys);
            n++;
            start = poke && (n == 2);
        end
        gotRes = resultVal;
        gotWr  = resultWrite;
        @(negedge clk_sys);
    endtask : run_op

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Trap pushes.
    task automatic t_trap(input logic [15:0] oldPc, vec, input logic [7:0] oldSp);
        logic [7:0] newSp;
        // The pointer wraps in eight bits, so the expectation is formed at that width.
        newSp     = oldSp - 8'h03;
        vectorVal = vec;
        run_op(OP_TRAP, 8'h00, 8'h00, 1'b0, nCyc);
        check(16'(nCyc), 16'd8);
        check(16'(wrAddr.size()), 16'd2);
        if (wrAddr.size() == 2) begin
            check({wrWide[0], wrAddr[0]}, {1'b1, oldSp - 8'h02});
            check(wrData[0], oldPc);
            check({wrWide[1], wrAddr[1]}, {1'b0, newSp});
            check(wrData[1][7:0], expFlags);
        end
        check(pc, vec);
        check({8'h00, sp}, {8'h00, newSp});
        check(flags, expFlags);
        check({fetchCycles, execCycles}, {3'h2, 3'h6});
    endtask : t_trap

    task automatic t_sub(input logic [7:0] op, d, s, input logic poke);
        expFlags = sub_flags(d, s, expFlags);
        run_op(op, d, s, poke, nCyc);
        check(16'(nCyc), 16'd7);
        check({gotWr, gotRes}, {1'b1, d - s});
        check(flags, expFlags);
        check({fetchCycles, execCycles}, {3'h4, 3'h3});
    endtask : t_sub

    task automatic t_swap(input logic [7:0] op, d, input int ex);
        expFlags = zs_flags({d[3:0], d[7:4]}, expFlags, 1'b0);
        run_op(op, d, 8'h00, 1'b0, nCyc);
        check({gotWr, gotRes}, {1'b1, d[3:0], d[7:4]});
        check(flags, expFlags);
        check(16'(nCyc), 16'(2 + ex));
        check({fetchCycles, execCycles}, {3'h2, 3'(ex)});
    endtask : t_swap

    task automatic t_mask(input logic [7:0] op, d, s, input int fe, ex);
        logic [7:0] v;
        // The plain form owns the upper opcode group; the complemented form the lower.
        v = (op >= OP_TAND_LO) ? (d & s) : (~d & s);
        expFlags = zs_flags(v, expFlags, 1'b1);
        run_op(op, d, s, 1'b0, nCyc);
        check(gotWr, 1'b0);
        check(flags, expFlags);
        check(16'(nCyc), 16'(fe + ex));
        check({fetchCycles, execCycles}, {3'(fe), 3'(ex)});
    endtask : t_mask

    task automatic t_wdog();
        run_op(OP_WDOG, 8'h00, 8'h00, 1'b0, nCyc);
        check(16'(nCyc), 16'd3);
        check(flags, expFlags);
        check({fetchCycles, execCycles}, {3'h1, 3'h2});
        repeat (20) @(negedge clk_sys);
        run_op(OP_WDOG, 8'h00, 8'h00, 1'b0, nCyc);
        repeat (20) @(negedge clk_sys);
        check(wdogTimeout, 1'b0);
        repeat (40) @(negedge clk_sys);
        check(wdogTimeout, 1'b1);
    endtask : t_wdog

    task automatic t_reset_mid();
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        check({pc}, {PC_RESET});
        check({8'h00, sp}, {8'h00, SP_RESET});
        check({wdogTimeout, busy, flags}, {2'b00, FLAGS_RESET});
    endtask : t_reset_mid

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (8) @(negedge clk_sys);
        reset    = 1'b0;
        expFlags = FLAGS_RESET;
        t_trap(PC_RESET, 16'h1234, SP_RESET);
        t_trap(16'h1234, 16'h0ABC, SP_RESET - 8'h03);
        t_sub(OP_SUBF_RR, 8'h10, 8'h21, 1'b1);
        t_swap(OP_SWAP_R, 8'hA5, 2);
        t_swap(OP_SWAP_PTR, 8'h0F, 3);
        t_sub(OP_SUBF_LIT, 8'h80, 8'h01, 1'b0);
        for (int i = 0; i < 6; i++) begin
            t_mask(OP_TCOMP_LO + 8'(i), (i % 2 == 0) ? 8'hF0 : 8'h70, 8'h8F, feTab[i],
                   exTab[i]);
            t_mask(OP_TAND_LO + 8'(i), 8'h0F, (i % 2 == 0) ? 8'hF0 : 8'h8F, feTab[i],
                   exTab[i]);
        end
        t_mask(OP_TCMF_RR, 8'hFF, 8'h55, 4, 3);
        t_mask(OP_TCMF_LIT, 8'h00, 8'hC3, 4, 3);
        t_mask(OP_TMF_RR, 8'hF0, 8'hF1, 4, 3);
        t_mask(OP_TMF_LIT, 8'h0F, 8'hF0, 4, 3);
        t_wdog();
        // A second reset in mid-run must clear the timeout, the flags and the pointers.
        t_reset_mid();
        wrap_up();
    end

    // Generous bound: the sequence needs well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge clk_sys);
        num_errors++;
        $display("[FAIL] t=%0t seen=%h expected=%h", $time, 16'h0000, 16'h0001);
        wrap_up();
    end
endmodule : cpu_test_swap_trap_exec_tb
